// [tcp_timer.sv]
// prescaled 8/16-bit timer/counter with apb registers
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ns
module tcp_timer
   import tcp_pkg::*;
(
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // pins
   input  wire logic        count_input_pin,
   output logic             irq
);
   import tcp_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   tcp_control_t ctrl;
   logic [7:0]   count_low_byte;
   logic [7:0]   count_live_high;
   logic [7:0]   count_high_buffer;
   logic         overflow_flag;
   logic         overflow_irq_enable;
   logic         sleep_mode;
   logic [7:0]   prescale_count;
   logic [1:0]   hold_count;
   logic [2:0]   pin_sync;
   logic         pin_level;
   logic         pin_prev;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic access;
   logic setup;
   logic wr;
   logic rd;
   logic mapped;
   logic wr_low;
   logic wr_high;
   logic wr_control;
   logic wr_status;
   logic wr_mask;
   logic wr_sleep;
   logic rd_low;
   // access phase: the one edge at which a transfer takes effect
   assign access     = psel & penable;
   // setup phase: the answer is registered here, one cycle ahead
   assign setup      = psel & ~penable;
   assign wr         = access & pwrite;
   assign rd         = access & ~pwrite;
   assign mapped     = paddr inside {ADDR_CONTROL, ADDR_LOW, ADDR_HIGH,
                                     ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_SLEEP};
   // per-register strobes, each high for the single access edge
   assign wr_low     = wr & (paddr == ADDR_LOW);
   assign wr_high    = wr & (paddr == ADDR_HIGH);
   assign wr_control = wr & (paddr == ADDR_CONTROL);
   assign wr_status  = wr & (paddr == ADDR_IRQ_STATUS);
   assign wr_mask    = wr & (paddr == ADDR_IRQ_MASK);
   assign wr_sleep   = wr & (paddr == ADDR_SLEEP);
   assign rd_low     = rd & (paddr == ADDR_LOW);

   // ------------------------------------------------------------
   // pin synchroniser and edge detect
   // ------------------------------------------------------------
   // three stages; the first may go metastable and is read by the second only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync <= 3'h0;
      end else begin
         pin_sync <= {pin_sync[1:0], count_input_pin};
      end
   end

   // a level is taken only once the last two stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_level <= 1'b0;
      end else if (pin_sync[1] == pin_sync[2]) begin
         pin_level <= pin_sync[2];
      end
   end

   // resets low like the idle pin, so no false edge follows reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= pin_level;
      end
   end

   logic pin_rise;
   logic pin_fall;
   logic pin_edge;
   logic source_tick;
   assign pin_rise = ~pin_prev & pin_level;
   assign pin_fall = pin_prev & ~pin_level;

   // edge select only matters while the pin is the count source
   always_comb begin
      if (ctrl.edge_select) begin
         pin_edge = pin_fall;
      end else begin
         pin_edge = pin_rise;
      end
   end

   // the internal source ticks on every instruction cycle, one per pclk
   always_comb begin
      if (ctrl.clock_source_select) begin
         source_tick = pin_edge;
      end else begin
         source_tick = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // prescaler
   // ------------------------------------------------------------
   logic       active;
   logic       prescale_tick;
   logic       prescale_run;
   logic       hold_clear;
   logic       divided_tick;
   logic       count_tick;
   logic [7:0] ratio_mask;
   // sleep stops both the counter and the prescaler
   assign active = ctrl.run_control & ~sleep_mode;

   // low prescaler bits that must all be set for one output tick
   always_comb begin
      ratio_mask = 8'h01;
      unique case (ctrl.prescale_ratio)
         3'h0: ratio_mask = 8'h01;
         3'h1: ratio_mask = 8'h03;
         3'h2: ratio_mask = 8'h07;
         3'h3: ratio_mask = 8'h0f;
         3'h4: ratio_mask = 8'h1f;
         3'h5: ratio_mask = 8'h3f;
         3'h6: ratio_mask = 8'h7f;
         3'h7: ratio_mask = 8'hff;
      endcase
   end

   assign prescale_tick = source_tick & ((prescale_count & ratio_mask) == ratio_mask);
   // the prescaler only advances while it is assigned and the block runs
   assign prescale_run  = active & source_tick & ~ctrl.prescaler_bypass;
   assign hold_clear    = (hold_count == 2'h0);
   // bypass takes every source tick, otherwise only the prescaler carry
   assign divided_tick  = ctrl.prescaler_bypass ? source_tick : prescale_tick;
   assign count_tick    = active & hold_clear & divided_tick;

   // a counter write restarts the division, so the next count is a full period, or two at ratio 0 where the hold drops the first carry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_count <= 8'h00;
      end else if (wr_low && !ctrl.prescaler_bypass) begin
         prescale_count <= 8'h00;
      end else if (prescale_run) begin
         prescale_count <= prescale_count + 8'h01;
      end
   end

   // with the prescaler bypassed, software may write a value two ahead to make up for the hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_count <= 2'h0;
      end else if (wr_low) begin
         hold_count <= WRITE_HOLD_CYCLES;
      end else if (hold_count != 2'h0) begin
         hold_count <= hold_count - 2'h1;
      end
   end

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   logic low_carry;
   logic wrap;
   // the low byte carries out on every ff to 00 step of a count tick
   assign low_carry = count_tick && (count_low_byte == 8'hff);
   // 8-bit mode wraps on the low carry alone; 16-bit needs the high byte full
   assign wrap      = low_carry &&
                      (ctrl.width_select || count_live_high == 8'hff);

   // low byte: loaded by a counter write, else advances on each count tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_low_byte <= 8'h00;
      end else if (wr_low) begin
         count_low_byte <= pwdata[7:0];
      end else if (count_tick) begin
         count_low_byte <= count_low_byte + 8'h01;
      end
   end

   // live high byte: only reachable through the buffer, frozen in 8-bit mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_live_high <= 8'h00;
      end else if (wr_low && !ctrl.width_select) begin
         count_live_high <= count_high_buffer;
      end else if (low_carry && !ctrl.width_select) begin
         count_live_high <= count_live_high + 8'h01;
      end
   end

   // the buffer snapshots the live high byte one edge after the low byte is sampled, so a carry at the setup edge tears a 16-bit read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_high_buffer <= HIGH_RESET;
      end else if (wr_high) begin
         count_high_buffer <= pwdata[7:0];
      end else if (rd_low && !ctrl.width_select) begin
         count_high_buffer <= count_live_high;
      end
   end

   // ------------------------------------------------------------
   // control and interrupt registers
   // ------------------------------------------------------------
   // control may be rewritten at any time, also while counting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= tcp_control_t'(CONTROL_RESET);
      end else if (wr_control) begin
         ctrl <= tcp_control_t'(pwdata[7:0]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_irq_enable <= 1'b0;
      end else if (wr_mask) begin
         overflow_irq_enable <= pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_mode <= 1'b0;
      end else if (wr_sleep) begin
         sleep_mode <= pwdata[0];
      end
   end

   // set wins over a clear in the same cycle, so no overflow is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag <= 1'b0;
      end else if (wrap) begin
         overflow_flag <= 1'b1;
      end else if (wr_status && pwdata[0]) begin
         overflow_flag <= 1'b0;
      end
   end

   logic mask_clearing;
   logic next_irq;
   // a mask write that clears the enable drops irq at once, not a cycle late
   assign mask_clearing = wr_mask & ~pwdata[0];
   assign next_irq      = (overflow_flag | wrap) & overflow_irq_enable & ~mask_clearing;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   // ------------------------------------------------------------
   // apb answer
   // ------------------------------------------------------------
   // the live high byte is never read directly, only through its buffer
   logic [31:0] read_value;
   always_comb begin
      read_value = 32'h0000_0000;
      unique case (paddr)
         ADDR_CONTROL:    read_value = {24'h000000, ctrl};
         ADDR_LOW:        read_value = {24'h000000, count_low_byte};
         ADDR_HIGH:       read_value = {24'h000000, count_high_buffer};
         ADDR_IRQ_STATUS: read_value = {31'h00000000, overflow_flag};
         ADDR_IRQ_MASK:   read_value = {31'h00000000, overflow_irq_enable};
         ADDR_SLEEP:      read_value = {31'h00000000, sleep_mode};
         default:         read_value = 32'h0000_0000;
      endcase
   end

   // the answer is registered in the setup cycle and stands for exactly
   // the access cycle that follows; writes always read back zero
   logic [31:0] next_prdata;
   logic        next_pslverr;
   assign next_pslverr = ~mapped;
   assign next_prdata  = pwrite ? 32'h0000_0000 : read_value;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= next_pslverr;
         prdata  <= next_prdata;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end
endmodule

// [tcp_pkg.sv]
// package for the prescaled 8/16-bit timer/counter
package tcp_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CONTROL    = 12'h000;
   localparam logic [11:0] ADDR_LOW        = 12'h004;
   localparam logic [11:0] ADDR_HIGH       = 12'h008;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00c;
   localparam logic [11:0] ADDR_IRQ_MASK   = 12'h010;
   localparam logic [11:0] ADDR_SLEEP      = 12'h014;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int BIT_RUN    = 7;
   localparam int BIT_WIDTH  = 6;
   localparam int BIT_SOURCE = 5;
   localparam int BIT_EDGE   = 4;
   localparam int BIT_BYPASS = 3;
   localparam logic [7:0] CONTROL_RESET = 8'hff;
   localparam logic [7:0] HIGH_RESET    = 8'h00;
   localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic       run_control;
      logic       width_select;
      logic       clock_source_select;
      logic       edge_select;
      logic       prescaler_bypass;
      logic [2:0] prescale_ratio;
   } tcp_control_t;
   typedef struct packed {
      logic        overflow_irq;
      logic [15:0] count_value;
   } tcp_status_t;
endpackage

// [tcp_props.sv]
// assertions on the timer apb and interrupt ports
`timescale 1ns/1ns
module tcp_props (
   // apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pins
   input wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready missing after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("pready longer than one cycle");
   property p_acc; pready |-> psel && penable; endproperty
   a_acc: assert property (p_acc) else $error("pready outside access");
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("pslverr without pready or data");
   property p_map; pready && paddr > 12'h014 |-> pslverr; endproperty
   a_map: assert property (p_map) else $error("unmapped access accepted");
   property p_ok; pready && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   property p_wz; pready && pwrite |-> prdata == 32'h0; endproperty
   a_wz: assert property (p_wz) else $error("read data on write");
   property p_irq; $fell(irq) |-> $past(pwrite && penable) || $past(pwrite && penable, 2);
   endproperty
   a_irq: assert property (p_irq) else $error("irq dropped without write");
endmodule

// [tcp_pin_model.sv]
// external count pin driver
`timescale 1ns/1ns
module tcp_pin_model (
   // clock and pin
   input wire logic pclk,
   output logic     count_input_pin
);
   initial count_input_pin = 1'b0;
   // six cycle phases keep each level long enough to be synchronised
   task automatic burst(input int n);
      count_input_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         count_input_pin <= 1'b1;
         repeat (6) @(posedge pclk);
         if (i == n - 1) break;
         count_input_pin <= 1'b0;
         repeat (6) @(posedge pclk);
      end
   endtask
endmodule

// [tb_top.sv]
// self-checking bench for the prescaled timer
`timescale 1ns/1ns
module tb_top;
   import tcp_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic        count_input_pin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          n_errors, n_checks, seed, v, n, k;
   tcp_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                  .pready, .pslverr, .count_input_pin, .irq);
   tcp_pin_model pm (.pclk, .count_input_pin);
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (t == 50) begin
         n_errors++;
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
   endtask
   task automatic idle(input int c);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (c) @(posedge pclk);
   endtask
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      seed = 98;
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      check("control", {24'h0, CONTROL_RESET}, rd);
      apb(1'b0, ADDR_IRQ_MASK, 32'h0);
      check("mask", 32'h0, rd);
      apb(1'b0, 12'h018, 32'h0);
      check("unmapped", 32'h1, {31'h0, er});
      $display("test reset done");
      v = $random(seed) & 32'hf0;
      n = $random(seed) & 32'hff;
      apb(1'b1, ADDR_CONTROL, 32'h88);
      apb(1'b1, ADDR_HIGH, n);
      apb(1'b1, ADDR_LOW, v);
      apb(1'b0, ADDR_LOW, 32'h0);
      apb(1'b0, ADDR_LOW, 32'h0);
      check("low held", v, rd);
      apb(1'b0, ADDR_LOW, 32'h0);
      check("low step", v + 2, rd);
      apb(1'b0, ADDR_HIGH, 32'h0);
      check("high", n, rd);
      $display("test write hold done");
      for (int c = 0; c < 9; c++) begin
         apb(1'b1, ADDR_CONTROL, c < 8 ? 32'hc0 | c : 32'hc8);
         apb(1'b0, ADDR_LOW, 32'h0);
         v = rd;
         idle(8 * (c < 8 ? 2 << c : 1) - 2);
         apb(1'b0, ADDR_LOW, 32'h0);
         check("prescaled", (v + 8) & 32'hff, rd);
      end
      apb(1'b1, ADDR_CONTROL, 32'hc7);
      idle(100);
      apb(1'b1, ADDR_LOW, 32'h0);
      idle(240);
      apb(1'b0, ADDR_LOW, 32'h0);
      check("cleared", 32'h0, rd);
      idle(20);
      apb(1'b0, ADDR_LOW, 32'h0);
      check("first", 32'h1, rd);
      $display("test prescaler done");
      apb(1'b1, ADDR_CONTROL, 32'hc8);
      apb(1'b1, ADDR_IRQ_MASK, 32'h1);
      apb(1'b1, ADDR_LOW, 32'hfd);
      idle(1);
      for (k = 0; k < 20 && irq !== 1'b1; k++) @(posedge pclk);
      check("irq set", 32'h1, {31'h0, irq});
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      idle(3);
      check("irq clear", 32'h0, {31'h0, irq});
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      idle(300);
      check("irq masked", 32'h0, {31'h0, irq});
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      check("flag", 32'h1, rd);
      $display("test overflow done");
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, ADDR_CONTROL, i ? 32'hc8 : 32'h48);
         apb(1'b1, ADDR_SLEEP, i);
         apb(1'b0, ADDR_LOW, 32'h0);
         v = rd;
         idle(20);
         apb(1'b0, ADDR_LOW, 32'h0);
         check("stopped", v, rd);
      end
      apb(1'b1, ADDR_SLEEP, 32'h0);
      $display("test stop done");
      for (int e = 1; e >= 0; e--) begin
         n = 1 + ($random(seed) & 7);
         apb(1'b1, ADDR_CONTROL, 32'he8 | (e << 4));
         apb(1'b1, ADDR_LOW, 32'h0);
         idle(1);
         pm.burst(n);
         idle(10);
         apb(1'b0, ADDR_LOW, 32'h0);
         check("pin count", n - e, rd);
      end
      $display("test pin done");
      print_verdict();
   end
endmodule
bind tcp_timer tcp_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
                                  .prdata, .pready, .pslverr, .irq);
